// >>> hw/tgrs_pkg.sv
// Package with constants and types of the trigger routing sequencer.
`default_nettype none
package tgrs_pkg;
    localparam int TGRS_PINS = 10;
    localparam int TGRS_DED  = 5;
    localparam int TGRS_SIGS = 13;
    localparam int TGRS_PIN_STROBE = 2;
    localparam int TGRS_PIN_CORE   = 3;
    // Internal timing signal indices.
    localparam int TGRS_SIG_START = 0;
    localparam int TGRS_SIG_POST  = 1;
    localparam int TGRS_SIG_SCAN  = 2;
    // Set bit means edge detection, clear bit means level detection.
    localparam logic [TGRS_SIGS-1:0] TGRS_EDGE_MASK = 13'h1FCF;
    // Output pulse timing.
    localparam int TGRS_CLK_NS       = 10;
    localparam int TGRS_PULSE_MIN_NS = 50;
    localparam int TGRS_PULSE_CYC    =
        (TGRS_PULSE_MIN_NS + TGRS_CLK_NS - 1) / TGRS_CLK_NS;
    localparam logic [3:0] TGRS_PULSE_LD = 4'(TGRS_PULSE_CYC);
    // Register byte addresses.
    localparam logic [7:0] TGRS_A_CTRL   = 8'h00;
    localparam logic [7:0] TGRS_A_STATUS = 8'h04;
    localparam logic [7:0] TGRS_A_OE     = 8'h08;
    localparam logic [7:0] TGRS_A_POL    = 8'h0C;
    localparam logic [7:0] TGRS_A_PRE    = 8'h10;
    localparam logic [7:0] TGRS_A_POSTC  = 8'h14;
    localparam logic [7:0] TGRS_A_SCNT   = 8'h18;
    localparam logic [7:0] TGRS_A_SRC    = 8'h40;
    localparam logic [7:0] TGRS_A_SRC_END = 8'h74;
    // Field positions.
    localparam int TGRS_CTRL_PRE   = 0;
    localparam int TGRS_CTRL_START = 1;
    localparam int TGRS_CTRL_STOP  = 2;
    localparam int TGRS_ST_DONE    = 2;
    localparam int TGRS_ST_POSTACC = 3;
    localparam int TGRS_ST_ACTIVE  = 4;

    typedef enum logic [1:0] {
        TGRS_IDLE  = 2'b00,
        TGRS_PRE   = 2'b01,
        TGRS_ARMED = 2'b10,
        TGRS_POST  = 2'b11
    } tgrs_state_t;

    typedef struct packed {
        logic       en;
        logic [3:0] pin;
    } tgrs_src_t;

    typedef struct packed {
        logic start;
        logic post;
        logic scan;
        logic done;
    } tgrs_evt_t;
endpackage : tgrs_pkg
`default_nettype wire

// >>> hw/tgrs_pin_sync.sv
// Two-stage synchroniser with a third stage for edge detection.
`timescale 1ns/100ps
`default_nettype none
module tgrs_pin_sync #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Raw pin levels
    input  wire logic [W-1:0] d,
    // Synchronised level and its previous value
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] prev
);
    logic [W-1:0] meta_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] prev_q;

    // The first stage is read only by the second stage.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            lvl_q  <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= d;
            lvl_q  <= meta_q;
            prev_q <= lvl_q;
        end
    end

    assign lvl  = lvl_q;
    assign prev = prev_q;
endmodule // tgrs_pin_sync
`default_nettype wire

// >>> hw/tgrs_top.sv
// Trigger routing and acquisition sequencing with an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module tgrs_top
    import tgrs_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Programmable function pins
    input  wire logic [TGRS_PINS-1:0] programmable_function_pin_i,
    output logic      [TGRS_PINS-1:0] programmable_function_pin_o,
    output logic      [TGRS_PINS-1:0] programmable_function_pin_oe_n,
    // Dedicated outputs
    output logic      [TGRS_DED-1:0]  dedicated_o,
    // Acquisition timing core
    input  wire logic                 conv_strobe_n,
    input  wire logic [TGRS_PINS-4:0] core_pin_sig,
    input  wire logic [TGRS_DED-1:0]  core_ded_sig,
    output logic      [TGRS_SIGS-1:0] routed_sig,
    output tgrs_evt_t                 seq_evt,
    output logic                      acq_active
);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    if (CNT_W < 1 || CNT_W > 32) begin : g_chk
        $error("CNT_W must lie between 1 and 32.");
    end
    if (TGRS_PULSE_CYC > 15) begin : g_chk_pulse
        $error("Pulse length does not fit its counter.");
    end

    function automatic logic src_hit(input logic [7:0] a);
        return a >= TGRS_A_SRC && a < TGRS_A_SRC_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic [3:0] src_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - TGRS_A_SRC;
        return d[5:2];
    endfunction

    // Registers.
    logic                 pre_mode_q;
    logic [TGRS_PINS-1:0] oe_q;
    logic [TGRS_PINS-1:0] pol_q;
    logic [CNT_W-1:0]     pre_cnt_q;
    logic [CNT_W-1:0]     post_cnt_q;
    tgrs_src_t            src_q [TGRS_SIGS];
    logic                 done_q;
    logic                 postacc_q;
    // Bus state.
    logic                 wr_q;
    logic [7:0]           waddr_q;
    logic [31:0]          hrdata_q;
    logic [31:0]          rd_d;
    logic                 ahb_go;
    logic                 wr_ctrl;
    logic                 sw_start;
    logic                 sw_stop;
    // Sequencer.
    tgrs_state_t          st_q;
    tgrs_state_t          st_d;
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic                 start_acc;
    logic                 post_acc;
    logic                 done_ev;
    logic                 scan_ok;
    // Routing.
    logic [TGRS_PINS-1:0] pin_lvl;
    logic [TGRS_PINS-1:0] pin_prev;
    logic [TGRS_PINS-1:0] pol_lvl;
    logic [TGRS_PINS-1:0] pol_prev;
    logic [TGRS_SIGS-1:0] routed_d;
    logic [TGRS_SIGS-1:0] routed_q;
    tgrs_evt_t            evt_q;
    logic [3:0]           pls_q [2];
    logic [TGRS_PINS-1:0] pin_o_d;
    logic [TGRS_PINS-1:0] pin_o_q;
    logic [TGRS_DED-1:0]  ded_q;

    // Pin synchronisation.
    tgrs_pin_sync #(
        .W       (TGRS_PINS)
    ) tgrs_pin_sync_inst (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (programmable_function_pin_i),
        .lvl     (pin_lvl),
        .prev    (pin_prev)
    );

    assign pol_lvl  = pin_lvl ^ pol_q;
    assign pol_prev = pin_prev ^ pol_q;

    // Source selection and detection for each internal timing signal.
    always_comb begin
        routed_d = '0;
        for (int i = 0; i < TGRS_SIGS; i++) begin
            if (src_q[i].en && src_q[i].pin < TGRS_PINS) begin
                if (TGRS_EDGE_MASK[i]) begin
                    routed_d[i] = pol_lvl[src_q[i].pin] &
                                  ~pol_prev[src_q[i].pin];
                end else begin
                    routed_d[i] = pol_lvl[src_q[i].pin];
                end
            end
        end
    end

    // Bus access decode.
    assign ahb_go   = hsel & htrans[1] & hready;
    assign wr_ctrl  = wr_q && waddr_q == TGRS_A_CTRL;
    assign sw_start = wr_ctrl & hwdata[TGRS_CTRL_START];
    assign sw_stop  = wr_ctrl & hwdata[TGRS_CTRL_STOP];

    // Sequencer next state.
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        start_acc = 1'b0;
        post_acc  = 1'b0;
        done_ev   = 1'b0;
        scan_ok   = routed_d[TGRS_SIG_SCAN] & (st_q != TGRS_IDLE);
        case (st_q)
            TGRS_IDLE: begin
                if (routed_d[TGRS_SIG_START] | sw_start) begin
                    start_acc = 1'b1;
                    if (!pre_mode_q) begin
                        st_d  = TGRS_POST;
                        cnt_d = post_cnt_q;
                    end else if (pre_cnt_q == '0) begin
                        st_d  = TGRS_ARMED;
                        cnt_d = post_cnt_q;
                    end else begin
                        st_d  = TGRS_PRE;
                        cnt_d = pre_cnt_q;
                    end
                end
            end
            TGRS_PRE: begin
                if (scan_ok) begin
                    if (cnt_q <= CNT_ONE) begin
                        st_d  = TGRS_ARMED;
                        cnt_d = post_cnt_q;
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
            end
            TGRS_ARMED: begin
                if (routed_d[TGRS_SIG_POST]) begin
                    post_acc = 1'b1;
                    st_d     = TGRS_POST;
                end
            end
            TGRS_POST: begin
                if (scan_ok) begin
                    if (cnt_q <= CNT_ONE) begin
                        st_d    = TGRS_IDLE;
                        cnt_d   = '0;
                        done_ev = 1'b1;
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
            end
            default: begin
                st_d  = TGRS_IDLE;
                cnt_d = '0;
            end
        endcase
        if (sw_stop && st_q != TGRS_IDLE) begin
            st_d     = TGRS_IDLE;
            cnt_d    = '0;
            post_acc = 1'b0;
            done_ev  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q  <= TGRS_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Sticky status flags; a set in the clearing cycle wins.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_q    <= 1'b0;
            postacc_q <= 1'b0;
        end else begin
            done_q <= done_ev | (done_q & ~(wr_q &&
                      waddr_q == TGRS_A_STATUS && hwdata[TGRS_ST_DONE]));
            if (post_acc) begin
                postacc_q <= 1'b1;
            end else if (start_acc) begin
                postacc_q <= 1'b0;
            end
        end
    end

    // Output pulses on pins 0 and 1, restarted by each new event.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pls_q[0] <= '0;
            pls_q[1] <= '0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if ((k == 0) ? start_acc : post_acc) begin
                    pls_q[k] <= TGRS_PULSE_LD;
                end else if (pls_q[k] != '0) begin
                    pls_q[k] <= pls_q[k] - 4'h1;
                end
            end
        end
    end

    // Fixed output signal of each pin.
    always_comb begin
        pin_o_d                  = '0;
        pin_o_d[TGRS_SIG_START]  = pls_q[0] != '0;
        pin_o_d[TGRS_SIG_POST]   = pls_q[1] != '0;
        pin_o_d[TGRS_PIN_STROBE] = conv_strobe_n;
        pin_o_d[TGRS_PINS-1:TGRS_PIN_CORE] = core_pin_sig;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_o_q  <= '0;
            ded_q    <= '0;
            routed_q <= '0;
            evt_q    <= '0;
        end else begin
            pin_o_q  <= pin_o_d;
            ded_q    <= core_ded_sig;
            routed_q <= routed_d;
            evt_q    <= '{start: start_acc, post: post_acc,
                          scan: scan_ok, done: done_ev};
        end
    end

    // Bus address phase capture.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_q    <= 1'b0;
            waddr_q <= '0;
        end else begin
            wr_q    <= ahb_go & hwrite;
            waddr_q <= haddr[7:0];
        end
    end

    // Register writes in the data phase.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pre_mode_q <= 1'b0;
            oe_q       <= '0;
            pol_q      <= '0;
            pre_cnt_q  <= '0;
            post_cnt_q <= '0;
            for (int i = 0; i < TGRS_SIGS; i++) begin
                src_q[i] <= '0;
            end
        end else if (wr_q) begin
            case (waddr_q)
                TGRS_A_CTRL:  pre_mode_q <= hwdata[TGRS_CTRL_PRE];
                TGRS_A_OE:    oe_q       <= hwdata[TGRS_PINS-1:0];
                TGRS_A_POL:   pol_q      <= hwdata[TGRS_PINS-1:0];
                TGRS_A_PRE:   pre_cnt_q  <= hwdata[CNT_W-1:0];
                TGRS_A_POSTC: post_cnt_q <= hwdata[CNT_W-1:0];
                default: begin
                    for (int i = 0; i < TGRS_SIGS; i++) begin
                        if (src_hit(waddr_q) && src_idx(waddr_q) == 4'(i)) begin
                            src_q[i] <= hwdata[4:0];
                        end
                    end
                end
            endcase
        end
    end

    // Read data selection.
    always_comb begin
        rd_d = '0;
        case (haddr[7:0])
            TGRS_A_CTRL:   rd_d[TGRS_CTRL_PRE] = pre_mode_q;
            TGRS_A_STATUS: begin
                rd_d[1:0]             = st_q;
                rd_d[TGRS_ST_DONE]    = done_q;
                rd_d[TGRS_ST_POSTACC] = postacc_q;
                rd_d[TGRS_ST_ACTIVE]  = st_q != TGRS_IDLE;
            end
            TGRS_A_OE:     rd_d[TGRS_PINS-1:0] = oe_q;
            TGRS_A_POL:    rd_d[TGRS_PINS-1:0] = pol_q;
            TGRS_A_PRE:    rd_d[CNT_W-1:0]     = pre_cnt_q;
            TGRS_A_POSTC:  rd_d[CNT_W-1:0]     = post_cnt_q;
            TGRS_A_SCNT:   rd_d[CNT_W-1:0]     = cnt_q;
            default: begin
                if (src_hit(haddr[7:0])) begin
                    rd_d[4:0] = src_q[src_idx(haddr[7:0])];
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hrdata_q <= '0;
        end else if (ahb_go && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    assign hrdata     = hrdata_q;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign routed_sig = routed_q;
    assign seq_evt    = evt_q;
    assign acq_active = st_q != TGRS_IDLE;
    assign dedicated_o = ded_q;
    assign programmable_function_pin_o    = pin_o_q;
    assign programmable_function_pin_oe_n = ~oe_q;
endmodule // tgrs_top
`default_nettype wire

// >>> verification/tgrs_properties.sv
// Checker of the trigger routing sequencer at its ports.
`timescale 1ns/100ps
`default_nettype none
module tgrs_properties
    import tgrs_pkg::*;
(
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    // Pins and dedicated outputs
    input wire logic [TGRS_PINS-1:0] programmable_function_pin_o,
    input wire logic [TGRS_PINS-1:0] programmable_function_pin_oe_n,
    input wire logic [TGRS_DED-1:0]  dedicated_o,
    // Core side
    input wire logic                 conv_strobe_n,
    input wire logic [TGRS_PINS-4:0] core_pin_sig,
    input wire logic [TGRS_DED-1:0]  core_ded_sig,
    input wire tgrs_evt_t            seq_evt,
    input wire logic                 acq_active
);
    wire logic [9:0] p_o  = programmable_function_pin_o;
    wire logic [9:0] p_oe = programmable_function_pin_oe_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    reset_pins_off_a:
        assert property ($past(sys_rst) |-> &p_oe && p_o[1:0] == 2'h0)
        else $error("pins driven after reset");
    start_pulse_a:
        assert property (seq_evt.start |=> p_o[0] [*5])
        else $error("start pulse too short");
    post_pulse_a:
        assert property (seq_evt.post |=> p_o[1] [*5])
        else $error("posttrigger pulse too short");
    start_from_idle_a:
        assert property (seq_evt.start |-> acq_active && !$past(acq_active))
        else $error("start outside idle");
    post_in_run_a:
        assert property (seq_evt.post |-> acq_active && $past(acq_active))
        else $error("posttrigger outside a run");
    scan_gated_a:
        assert property (seq_evt.scan |-> $past(acq_active))
        else $error("scan passed while idle");
    done_closes_a:
        assert property (seq_evt.done |-> ##[0:1] !acq_active)
        else $error("run not closed at done");
    start_single_a:
        assert property (seq_evt.start |=> !seq_evt.start)
        else $error("start event longer than a cycle");
    strobe_pin_a:
        assert property (!$past(sys_rst) && !p_oe[2]
                         |-> p_o[2] == $past(conv_strobe_n))
        else $error("strobe not on pin two");
    ded_out_a:
        assert property (!$past(sys_rst) |-> dedicated_o == $past(core_ded_sig))
        else $error("dedicated output wrong");
    core_pins_a:
        assert property (!$past(sys_rst) |-> p_o[9:3] == $past(core_pin_sig))
        else $error("core signal not on its pin");
    post_seen_c: cover property (seq_evt.post);
    done_seen_c: cover property (seq_evt.done);
    scan_seen_c: cover property (seq_evt.scan);
endmodule // tgrs_properties
bind tgrs_top tgrs_properties tgrs_properties_inst (.*);
`default_nettype wire

// >>> verification/tgrs_trig_src.sv
// Model of the external trigger sources facing the function pins.
`timescale 1ns/100ps
`default_nettype none
module tgrs_trig_src
    import tgrs_pkg::*;
(
    // Clock
    input  wire logic                 sys_clk,
    // Device side of the pins
    input  wire logic [TGRS_PINS-1:0] oe_n,
    input  wire logic [TGRS_PINS-1:0] dev_o,
    // Resolved pin levels
    output logic      [TGRS_PINS-1:0] pin_lvl
);
    logic [TGRS_PINS-1:0] ext_q = '0;
    // The source lets go of every pin that the device drives.
    always_comb pin_lvl = (ext_q & oe_n) | (dev_o & ~oe_n);
    // Sets the resting level of one pin.
    task automatic idle_at(input int pin, input logic lvl);
        @(posedge sys_clk);
        ext_q[pin] <= lvl;
        repeat (4) @(posedge sys_clk);
    endtask
    // Inverts one pin for hold cycles, restores it, then rests.
    task automatic pulse(input int pin, input int hold);
        @(posedge sys_clk);
        ext_q[pin] <= ~ext_q[pin];
        repeat (hold) @(posedge sys_clk);
        ext_q[pin] <= ~ext_q[pin];
        repeat (8) @(posedge sys_clk);
    endtask
endmodule // tgrs_trig_src
`default_nettype wire

// >>> verification/trigger_routing_sequencer_tb.sv
// Self-checking bench of the trigger routing sequencer.
`timescale 1ns/100ps
`default_nettype none
module trigger_routing_sequencer_tb;
    import tgrs_pkg::*;
    logic            sys_clk       = 1'b0;
    logic            sys_rst       = 1'b1;
    logic            hsel          = 1'b0;
    logic            hwrite        = 1'b0;
    logic [1:0]      htrans        = 2'h0;
    logic [31:0]     haddr         = 32'h0;
    logic [31:0]     hwdata        = 32'h0;
    logic            conv_strobe_n = 1'b1;
    logic [6:0]      core_pin_sig  = 7'h0;
    logic [4:0]      core_ded_sig  = 5'h0;
    wire logic [31:0] hrdata;
    wire logic       hreadyout;
    wire logic       hresp;
    wire logic       acq_active;
    wire logic [9:0] pin_i;
    wire logic [9:0] pin_o;
    wire logic [9:0] pin_oe_n;
    wire logic [4:0] dedicated_o;
    wire logic [12:0] routed_sig;
    wire tgrs_evt_t  seq_evt;
    int miscompares = 0;
    int check_count = 0;
    int n_start = 0;
    int n_post = 0;
    int n_scan = 0;
    int n_done = 0;
    int n_hi0 = 0;
    int n_hi1 = 0;
    int n_rt = 0;
    int pin_start;
    int pin_post;
    int pin_scan;

    always #5 sys_clk = ~sys_clk;

    // Counts events and driven pulse cycles, and stirs the core inputs.
    always @(posedge sys_clk) begin
        n_start <= n_start + int'(seq_evt.start === 1'b1);
        n_post <= n_post + int'(seq_evt.post === 1'b1);
        n_scan <= n_scan + int'(seq_evt.scan === 1'b1);
        n_done <= n_done + int'(seq_evt.done === 1'b1);
        n_hi0 <= n_hi0 + int'(pin_i[0] === 1'b1);
        n_hi1 <= n_hi1 + int'(pin_i[1] === 1'b1);
        n_rt <= n_rt + int'(routed_sig[TGRS_SIG_SCAN] === 1'b1);
        conv_strobe_n <= 1'($urandom);
        core_pin_sig <= 7'($urandom);
        core_ded_sig <= 5'($urandom);
    end

    tgrs_top tgrs_top_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .programmable_function_pin_i(pin_i),
        .programmable_function_pin_o(pin_o),
        .programmable_function_pin_oe_n(pin_oe_n), .dedicated_o(dedicated_o),
        .conv_strobe_n(conv_strobe_n), .core_pin_sig(core_pin_sig),
        .core_ded_sig(core_ded_sig), .routed_sig(routed_sig),
        .seq_evt(seq_evt), .acq_active(acq_active)
    );
    tgrs_trig_src tgrs_trig_src_inst (
        .sys_clk(sys_clk), .oe_n(pin_oe_n), .dev_o(pin_o), .pin_lvl(pin_i)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; called right after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        chk(got, exp);
    endtask

    task automatic scans(input int n);
        repeat (n) tgrs_trig_src_inst.pulse(pin_scan, 1 + $urandom % 4);
    endtask

    function automatic logic [31:0] status_exp(input logic [1:0] st,
        input logic dn, input logic pa, input logic ac);
        return {27'h0, ac, pa, dn, st};
    endfunction

    function automatic logic [7:0] src_addr(input int i);
        return TGRS_A_SRC + 8'(4 * i);
    endfunction

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        int k;
        int m;
        int n;
        void'($urandom(32'hB46F));
        pin_start = 3 + $urandom % 3;
        pin_post = 6 + $urandom % 2;
        pin_scan = 8 + $urandom % 2;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk({22'h0, pin_oe_n}, 32'h3FF);
        rd_chk(TGRS_A_STATUS, 32'h0);
        rd_chk(8'h30, 32'h0);
        wr(TGRS_A_OE, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk({22'h0, pin_oe_n}, 32'h3F8);
        wr(src_addr(TGRS_SIG_START), 32'h10 | pin_start);
        wr(src_addr(TGRS_SIG_POST), 32'h10 | pin_post);
        wr(src_addr(TGRS_SIG_SCAN), 32'h10 | pin_scan);
        wr(TGRS_A_POL, 32'h1 << pin_post);
        tgrs_trig_src_inst.idle_at(pin_post, 1'b1);
        rd_chk(src_addr(TGRS_SIG_POST), 32'h10 | pin_post);
        $display("test registers done");
        n = 2 + $urandom % 4;
        wr(TGRS_A_POSTC, n);
        wr(TGRS_A_CTRL, 32'h0);
        scans(1);
        chk(n_scan, 0);
        tgrs_trig_src_inst.pulse(pin_start, 1 + $urandom % 6);
        chk(n_start, 1);
        rd_chk(TGRS_A_STATUS, status_exp(2'h3, 1'h0, 1'h0, 1'h1));
        tgrs_trig_src_inst.pulse(pin_post, 2);
        chk(n_post, 0);
        scans(n);
        chk(n_scan, n);
        chk(n_done, 1);
        rd_chk(TGRS_A_STATUS, status_exp(2'h0, 1'h1, 1'h0, 1'h0));
        $display("test posttriggered done");
        k = 1 + $urandom % 3;
        m = 1 + $urandom % 3;
        wr(TGRS_A_PRE, k);
        wr(TGRS_A_POSTC, m);
        wr(TGRS_A_STATUS, 32'h4);
        wr(TGRS_A_CTRL, 32'h1);
        wr(TGRS_A_CTRL, 32'h3);
        repeat (3) @(posedge sys_clk);
        chk(n_start, 2);
        tgrs_trig_src_inst.pulse(pin_post, 3);
        chk(n_post, 0);
        scans(k);
        rd_chk(TGRS_A_STATUS, status_exp(2'h2, 1'h0, 1'h0, 1'h1));
        rd_chk(TGRS_A_SCNT, m);
        tgrs_trig_src_inst.pulse(pin_post, 1 + $urandom % 6);
        chk(n_post, 1);
        rd_chk(TGRS_A_STATUS, status_exp(2'h3, 1'h0, 1'h1, 1'h1));
        scans(m);
        chk(n_done, 2);
        chk(n_scan, n + k + m);
        chk(n_rt, 1 + n + k + m);
        $display("test pretriggered done");
        tgrs_trig_src_inst.pulse(pin_start, 2);
        chk(n_start, 3);
        wr(TGRS_A_CTRL, 32'h5);
        repeat (3) @(posedge sys_clk);
        chk(n_done, 3);
        chk({31'h0, acq_active}, 32'h0);
        tgrs_trig_src_inst.pulse(pin_post, 2);
        chk(n_post, 1);
        chk(n_hi0, 5 * 3);
        chk(n_hi1, 5);
        $display("test abort done");
        tally_and_finish();
    end
endmodule // trigger_routing_sequencer_tb
`default_nettype wire
